// ==== tbrfe_card.sv ====
// behavioural proximity card answering the reader with one frame
module tbrfe_card (
	// clock and field
	input wire logic clock,
	input wire logic rf_mod,
	// scenario control
	input wire logic go,
	input wire logic [7:0] resp [0:2],
	input wire logic [9:0] gap,
	// load modulation
	output logic sub_on_pin,
	output logic sub_phase_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int E = tbrfe_pkg::ETU_I;
	int q;
	logic seen;
	// reference phase stands for one
	task automatic lvl(input logic v, input int n);
		repeat (n)
		begin
			sub_phase_pin <= v;
			@(posedge clock);
		end
	endtask : lvl
	initial
	begin
		sub_on_pin <= 1'b0;
		sub_phase_pin <= 1'b0;
		q = 0;
		seen = 1'b0;
		forever
		begin
			@(posedge clock);
			// no subcarrier: phase pin carries a changing pattern
			sub_phase_pin <= ~sub_phase_pin;
			q = rf_mod ? 0 : q + 1;
			seen |= rf_mod;
			if (go && seen && q == 8 * E + 40)
			begin
				seen = 1'b0;
				sub_on_pin <= 1'b1;
				lvl(1'b1, 3 * E);
				lvl(1'b0, 10 * E);
				lvl(1'b1, 2 * E);
				foreach (resp[i])
				begin
					lvl(1'b0, E);
					for (int b = 0; b < 8; b++)
						lvl(resp[i][b], E);
					lvl(1'b1, E);
					lvl(1'b1, int'(gap));
				end
				lvl(1'b0, 10 * E);
				lvl(1'b1, E);
				sub_on_pin <= 1'b0;
			end
		end
	end
endmodule : tbrfe_card

// ==== tbrfe_crc.sv ====
// serial crc register, one bit per enable, in line order
module tbrfe_crc (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// control
	input wire logic init,
	input wire logic en,
	input wire logic bit_in,
	// result
	output logic [15:0] crc
);
	logic [15:0] crc_r;
	logic fb;

	assign fb = bit_in ^ crc_r[15];
	assign crc = crc_r;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			crc_r <= tbrfe_pkg::CRC_PRESET;
		else if (init)
			crc_r <= tbrfe_pkg::CRC_PRESET;
		else if (en)
			crc_r <= {crc_r[14:0], 1'b0} ^ (fb ? tbrfe_pkg::CRC_POLY : 16'h0000);
	end

endmodule : tbrfe_crc

// ==== tbrfe_fifo.sv ====
// parameterised flip-flop fifo with valid and ready on both sides
module tbrfe_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);
	localparam logic [AW:0] CNT_FULL = (AW + 1)'(D);

	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic in_ready_r;
	logic out_valid_r;
	logic wr;
	logic rd;

	assign wr = in_valid && in_ready_r;
	assign rd = out_valid_r && out_ready;
	assign in_ready = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data = mem_r[rp_r];

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (wr && !rd)
			cnt_nxt = cnt_r + 1'b1;
		else if (rd && !wr)
			cnt_nxt = cnt_r - 1'b1;
	end

	genvar i;
	for (i = 0; i < D; i++)
	begin : g_entry
		always_ff @(posedge clock or posedge reset)
		begin
			if (reset)
				mem_r[i] <= '0;
			else if (wr && wp_r == AW'(i))
				mem_r[i] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready_r <= 1'b0;
			out_valid_r <= 1'b0;
		end
		else
		begin
			if (wr)
				wp_r <= (wp_r == PTR_LAST) ? '0 : wp_r + 1'b1;
			if (rd)
				rp_r <= (rp_r == PTR_LAST) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_nxt;
			in_ready_r <= cnt_nxt != CNT_FULL;
			out_valid_r <= cnt_nxt != '0;
		end
	end

endmodule : tbrfe_fifo

// ==== tbrfe_pkg.sv ====
// constants, timing counts and state encodings of the type b frame engine
package tbrfe_pkg;

	// clock and bit timing
	localparam real CLK_MHZ = 20.0;
	localparam real ETU_US = 9.4395;
	localparam real EGT_MAX_US = 19.0;
	localparam int ETU_I = int'(ETU_US * CLK_MHZ);
	localparam int EGT_I = int'($floor(EGT_MAX_US * CLK_MHZ));
	localparam int TOL_I = ETU_I / 8;
	localparam logic [15:0] ETU_CYC = 16'(ETU_I);
	localparam logic [15:0] ETU_M1 = 16'(ETU_I - 1);
	localparam logic [15:0] HALF_CYC = 16'(ETU_I / 2);
	localparam logic [15:0] GAP_MAX = 16'(ETU_I / 2 + EGT_I + TOL_I);

	// receive marker windows in cycles
	localparam logic [15:0] SOFL_MIN = 16'(10 * ETU_I - TOL_I);
	localparam logic [15:0] SOFL_MAX = 16'(11 * ETU_I + TOL_I);
	localparam logic [15:0] SOFH_MIN = 16'(2 * ETU_I - TOL_I);
	localparam logic [15:0] SOFH_MAX = 16'(3 * ETU_I + TOL_I);
	localparam logic [15:0] EOF_MIN = 16'(ETU_I / 2 - TOL_I);
	localparam logic [15:0] EOF_MAX = 16'(ETU_I + ETU_I / 2 + TOL_I);
	localparam logic [15:0] TR1_TMO = 16'hffff;

	// durations in whole etu, and the largest fwi exponent
	localparam logic [19:0] SOF_LO_ETU = 20'h0000a;
	localparam logic [19:0] SOF_HI_ETU = 20'h00002;
	localparam logic [19:0] EOF_ETU = 20'h0000a;
	localparam logic [19:0] TR0_MIN_ETU = 20'h00008;
	localparam logic [19:0] ATQB_ETU = 20'h00020;
	localparam int FWT_BASE_ETU = 32;
	localparam logic [3:0] FWI_MAX = 4'he;

	// character layout
	localparam logic [3:0] BIT_START = 4'h0;
	localparam logic [3:0] BIT_LAST_DATA = 4'h8;
	localparam logic [3:0] BIT_STOP = 4'h9;

	// crc
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_PRESET = 16'hffff;

	// transmit buffer: byte plus last flag
	localparam int FIFO_W = 9;
	localparam int FIFO_D = 8;

	typedef enum logic [6:0] {
		T_IDLE = 7'h01,
		T_SOFL = 7'h02,
		T_SOFH = 7'h04,
		T_CHAR = 7'h08,
		T_EOF = 7'h10,
		T_WAIT = 7'h20,
		T_SPARE = 7'h40
	} tbrfe_tx_e;

	typedef enum logic [6:0] {
		R_IDLE = 7'h01,
		R_TR1 = 7'h02,
		R_SOFL = 7'h04,
		R_SOFH = 7'h08,
		R_CHAR = 7'h10,
		R_GAP = 7'h20,
		R_EOF = 7'h40
	} tbrfe_rx_e;

endpackage : tbrfe_pkg

// ==== tbrfe_top.sv ====
// type b reader frame engine: transmit framer, response timing, receive deframer
module tbrfe_top #(
	parameter int FWT_BASE_ETU = tbrfe_pkg::FWT_BASE_ETU
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// host transmit stream
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	// response wait setting
	input wire logic [3:0] fwi,
	input wire logic atqb_wait,
	// rf front end
	output logic rf_mod_r,
	output logic carrier_on_r,
	input wire logic sub_on_pin,
	input wire logic sub_phase_pin,
	// host receive stream and status
	output logic [7:0] rx_data_r,
	output logic rx_valid_r,
	output logic rx_done_r,
	output logic rx_crc_err_r,
	output logic rx_frame_err_r,
	output logic resp_timeout_r,
	output logic tx_underrun_r,
	output logic busy_r
);
	tbrfe_pkg::tbrfe_tx_e tx_st_r;
	tbrfe_pkg::tbrfe_rx_e rx_st_r;

	logic [1:0] son_r;
	logic [1:0] sph_r;
	logic sub_on_s;
	logic sub_ph_s;
	logic [15:0] tcnt_r;
	logic tick;
	logic [19:0] ecnt_r;
	logic [19:0] fwt_lim;
	logic [3:0] fwi_c;
	logic [9:0] shift_r;
	logic [3:0] bidx_r;
	logic [1:0] crc_ph_r;
	logic last_r;
	logic f_valid;
	logic f_pop;
	logic [8:0] f_data;
	logic stop_end;
	logic [15:0] tx_crc;
	logic tx_crc_en;
	logic [15:0] rx_crc;
	logic rx_crc_en;
	logic [15:0] rcnt_r;
	logic [3:0] rbidx_r;
	logic [7:0] rbyte_r;
	logic ref_r;
	logic [1:0] nb_r;
	logic crc_ok_r;
	logic lvl;
	logic samp;
	logic guard_ok;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int k = 0; k < 8; k++)
			r[k] = v[7 - k];
		return r;
	endfunction : rev8

	// pin synchronisers
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			son_r <= 2'h0;
			sph_r <= 2'h0;
		end
		else
		begin
			son_r <= {son_r[0], sub_on_pin};
			sph_r <= {sph_r[0], sub_phase_pin};
		end
	end
	assign sub_on_s = son_r[1];
	assign sub_ph_s = sph_r[1];

	tbrfe_fifo #(
		.W(tbrfe_pkg::FIFO_W),
		.D(tbrfe_pkg::FIFO_D)
	) u_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data({tx_last, tx_data}),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	// etu tick while the transmit side is active
	assign tick = tcnt_r == tbrfe_pkg::ETU_M1;
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			tcnt_r <= 16'h0000;
		else if (tx_st_r == tbrfe_pkg::T_IDLE || tick)
			tcnt_r <= 16'h0000;
		else
			tcnt_r <= tcnt_r + 1'b1;
	end

	assign fwi_c = (fwi > tbrfe_pkg::FWI_MAX) ? tbrfe_pkg::FWI_MAX : fwi;
	assign fwt_lim = atqb_wait ? tbrfe_pkg::ATQB_ETU : (20'(FWT_BASE_ETU) << fwi_c);
	assign stop_end = tx_st_r == tbrfe_pkg::T_CHAR && tick && bidx_r == tbrfe_pkg::BIT_STOP;
	assign guard_ok = tx_st_r == tbrfe_pkg::T_WAIT && ecnt_r >= tbrfe_pkg::TR0_MIN_ETU;

	// pop the next byte at the sof end or right at a stop bit end
	always_comb
	begin
		f_pop = 1'b0;
		if (tx_st_r == tbrfe_pkg::T_SOFH && tick && ecnt_r == tbrfe_pkg::SOF_HI_ETU - 1'b1)
			f_pop = f_valid;
		else if (stop_end && !last_r && crc_ph_r == 2'h0)
			f_pop = f_valid;
	end

	// data bits only feed the crc
	assign tx_crc_en = tx_st_r == tbrfe_pkg::T_CHAR && tick && crc_ph_r == 2'h0
		&& bidx_r < tbrfe_pkg::BIT_LAST_DATA;

	tbrfe_crc u_tx_crc (
		.clock(clock),
		.reset(reset),
		.init(tx_st_r == tbrfe_pkg::T_IDLE),
		.en(tx_crc_en),
		.bit_in(shift_r[1]),
		.crc(tx_crc)
	);

	// transmit framer and response wait
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			tx_st_r <= tbrfe_pkg::T_IDLE;
			ecnt_r <= 20'h00000;
			shift_r <= 10'h3ff;
			bidx_r <= 4'h0;
			crc_ph_r <= 2'h0;
			last_r <= 1'b0;
			rf_mod_r <= 1'b0;
			resp_timeout_r <= 1'b0;
			tx_underrun_r <= 1'b0;
		end
		else
		begin
			resp_timeout_r <= 1'b0;
			tx_underrun_r <= 1'b0;
			case (tx_st_r)
				tbrfe_pkg::T_IDLE:
				begin
					rf_mod_r <= 1'b0;
					if (f_valid)
					begin
						tx_st_r <= tbrfe_pkg::T_SOFL;
						ecnt_r <= 20'h00000;
						crc_ph_r <= 2'h0;
						last_r <= 1'b0;
						rf_mod_r <= 1'b1;
					end
				end
				tbrfe_pkg::T_SOFL:
					if (tick)
					begin
						ecnt_r <= ecnt_r + 1'b1;
						if (ecnt_r == tbrfe_pkg::SOF_LO_ETU - 1'b1)
						begin
							tx_st_r <= tbrfe_pkg::T_SOFH;
							ecnt_r <= 20'h00000;
							rf_mod_r <= 1'b0;
						end
					end
				tbrfe_pkg::T_SOFH:
					if (tick)
					begin
						ecnt_r <= ecnt_r + 1'b1;
						if (ecnt_r == tbrfe_pkg::SOF_HI_ETU - 1'b1)
						begin
							tx_st_r <= tbrfe_pkg::T_CHAR;
							shift_r <= {1'b1, f_data[7:0], 1'b0};
							last_r <= f_data[8];
							bidx_r <= 4'h0;
							rf_mod_r <= 1'b1;
						end
					end
				tbrfe_pkg::T_CHAR:
					if (stop_end)
					begin
						bidx_r <= 4'h0;
						rf_mod_r <= 1'b1;
						if (crc_ph_r == 2'h0 && !last_r && f_valid)
						begin
							shift_r <= {1'b1, f_data[7:0], 1'b0};
							last_r <= f_data[8];
						end
						else if (crc_ph_r == 2'h0)
						begin
							tx_underrun_r <= !last_r;
							shift_r <= {1'b1, rev8(tx_crc[15:8]), 1'b0};
							crc_ph_r <= 2'h1;
						end
						else if (crc_ph_r == 2'h1)
						begin
							shift_r <= {1'b1, rev8(tx_crc[7:0]), 1'b0};
							crc_ph_r <= 2'h2;
						end
						else
						begin
							tx_st_r <= tbrfe_pkg::T_EOF;
							ecnt_r <= 20'h00000;
						end
					end
					else if (tick)
					begin
						shift_r <= {1'b1, shift_r[9:1]};
						bidx_r <= bidx_r + 1'b1;
						rf_mod_r <= !shift_r[1];
					end
				tbrfe_pkg::T_EOF:
					if (tick)
					begin
						ecnt_r <= ecnt_r + 1'b1;
						if (ecnt_r == tbrfe_pkg::EOF_ETU - 1'b1)
						begin
							tx_st_r <= tbrfe_pkg::T_WAIT;
							ecnt_r <= 20'h00000;
							rf_mod_r <= 1'b0;
						end
					end
				tbrfe_pkg::T_WAIT:
				begin
					rf_mod_r <= 1'b0;
					if (tick && ecnt_r != 20'hfffff)
						ecnt_r <= ecnt_r + 1'b1;
					if (rx_done_r)
						tx_st_r <= tbrfe_pkg::T_IDLE;
					else if (rx_st_r == tbrfe_pkg::R_IDLE && tick && ecnt_r >= fwt_lim - 1'b1)
					begin
						tx_st_r <= tbrfe_pkg::T_IDLE;
						resp_timeout_r <= 1'b1;
					end
				end
				default:
					tx_st_r <= tbrfe_pkg::T_IDLE;
			endcase
		end
	end

	// carrier stays on; busy mirrors the framer
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			carrier_on_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else
		begin
			carrier_on_r <= 1'b1;
			busy_r <= tx_st_r != tbrfe_pkg::T_IDLE;
		end
	end

	// demodulated level: same phase as sync period means one
	assign lvl = sub_on_s ? (sub_ph_s == ref_r) : 1'b1;
	assign samp = rx_st_r == tbrfe_pkg::R_CHAR
		&& rcnt_r == ((rbidx_r == tbrfe_pkg::BIT_START) ? tbrfe_pkg::HALF_CYC : tbrfe_pkg::ETU_CYC);
	assign rx_crc_en = samp && rbidx_r != tbrfe_pkg::BIT_START && rbidx_r != tbrfe_pkg::BIT_STOP;

	tbrfe_crc u_rx_crc (
		.clock(clock),
		.reset(reset),
		.init(rx_st_r == tbrfe_pkg::R_IDLE),
		.en(rx_crc_en),
		.bit_in(lvl),
		.crc(rx_crc)
	);

	// receive deframer
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			rx_st_r <= tbrfe_pkg::R_IDLE;
			rcnt_r <= 16'h0000;
			rbidx_r <= 4'h0;
			rbyte_r <= 8'h00;
			ref_r <= 1'b0;
			nb_r <= 2'h0;
			crc_ok_r <= 1'b0;
			rx_data_r <= 8'h00;
			rx_valid_r <= 1'b0;
			rx_done_r <= 1'b0;
			rx_crc_err_r <= 1'b0;
			rx_frame_err_r <= 1'b0;
		end
		else
		begin
			rx_valid_r <= 1'b0;
			rx_done_r <= 1'b0;
			rx_crc_err_r <= 1'b0;
			rx_frame_err_r <= 1'b0;
			if (rcnt_r != tbrfe_pkg::TR1_TMO)
				rcnt_r <= rcnt_r + 1'b1;
			case (rx_st_r)
				tbrfe_pkg::R_IDLE:
				begin
					nb_r <= 2'h0;
					crc_ok_r <= 1'b0;
					if (guard_ok && sub_on_s && !rx_done_r)
					begin
						rx_st_r <= tbrfe_pkg::R_TR1;
						rcnt_r <= 16'h0000;
					end
				end
				tbrfe_pkg::R_TR1:
				begin
					if (rcnt_r == tbrfe_pkg::ETU_CYC)
						ref_r <= sub_ph_s;
					if (!sub_on_s || rcnt_r == tbrfe_pkg::TR1_TMO)
					begin
						rx_st_r <= tbrfe_pkg::R_IDLE;
						rx_done_r <= 1'b1;
						rx_frame_err_r <= 1'b1;
					end
					else if (rcnt_r > tbrfe_pkg::ETU_CYC && !lvl)
					begin
						rx_st_r <= tbrfe_pkg::R_SOFL;
						rcnt_r <= 16'h0000;
					end
				end
				tbrfe_pkg::R_SOFL:
					if (!sub_on_s || rcnt_r > tbrfe_pkg::SOFL_MAX
						|| (lvl && rcnt_r < tbrfe_pkg::SOFL_MIN))
					begin
						rx_st_r <= tbrfe_pkg::R_IDLE;
						rx_done_r <= 1'b1;
						rx_frame_err_r <= 1'b1;
					end
					else if (lvl)
					begin
						rx_st_r <= tbrfe_pkg::R_SOFH;
						rcnt_r <= 16'h0000;
					end
				tbrfe_pkg::R_SOFH:
					if (!sub_on_s || rcnt_r > tbrfe_pkg::SOFH_MAX
						|| (!lvl && rcnt_r < tbrfe_pkg::SOFH_MIN))
					begin
						rx_st_r <= tbrfe_pkg::R_IDLE;
						rx_done_r <= 1'b1;
						rx_frame_err_r <= 1'b1;
					end
					else if (!lvl)
					begin
						rx_st_r <= tbrfe_pkg::R_CHAR;
						rcnt_r <= 16'h0000;
						rbidx_r <= tbrfe_pkg::BIT_START;
					end
				tbrfe_pkg::R_CHAR:
					if (samp)
					begin
						rcnt_r <= 16'h0001;
						rbidx_r <= rbidx_r + 1'b1;
						if (rbidx_r == tbrfe_pkg::BIT_START && lvl)
						begin
							rx_st_r <= tbrfe_pkg::R_IDLE;
							rx_done_r <= 1'b1;
							rx_frame_err_r <= 1'b1;
						end
						else if (rbidx_r == tbrfe_pkg::BIT_STOP && lvl)
						begin
							rx_st_r <= tbrfe_pkg::R_GAP;
							rcnt_r <= 16'h0000;
							rx_data_r <= rbyte_r;
							rx_valid_r <= 1'b1;
							if (nb_r != 2'h2)
								nb_r <= nb_r + 1'b1;
							crc_ok_r <= rx_crc == 16'h0000;
						end
						else if (rbidx_r == tbrfe_pkg::BIT_STOP)
						begin
							rx_st_r <= (rbyte_r == 8'h00) ? tbrfe_pkg::R_EOF : tbrfe_pkg::R_IDLE;
							rcnt_r <= 16'h0000;
							rx_done_r <= rbyte_r != 8'h00;
							rx_frame_err_r <= rbyte_r != 8'h00;
						end
						else if (rbidx_r != tbrfe_pkg::BIT_START)
							rbyte_r <= {lvl, rbyte_r[7:1]};
					end
				tbrfe_pkg::R_GAP:
					if (!lvl)
					begin
						rx_st_r <= tbrfe_pkg::R_CHAR;
						rcnt_r <= 16'h0000;
						rbidx_r <= tbrfe_pkg::BIT_START;
					end
					else if (rcnt_r == tbrfe_pkg::GAP_MAX)
					begin
						rx_st_r <= tbrfe_pkg::R_IDLE;
						rx_done_r <= 1'b1;
						rx_frame_err_r <= 1'b1;
					end
				tbrfe_pkg::R_EOF:
					if (rcnt_r > tbrfe_pkg::EOF_MAX || (lvl && rcnt_r < tbrfe_pkg::EOF_MIN))
					begin
						rx_st_r <= tbrfe_pkg::R_IDLE;
						rx_done_r <= 1'b1;
						rx_frame_err_r <= 1'b1;
					end
					else if (lvl)
					begin
						rx_st_r <= tbrfe_pkg::R_IDLE;
						rx_done_r <= 1'b1;
						rx_crc_err_r <= !(crc_ok_r && nb_r == 2'h2);
					end
				default:
					rx_st_r <= tbrfe_pkg::R_IDLE;
			endcase
		end
	end

endmodule : tbrfe_top

// ==== tbrfe_top_asserts.sv ====
// concurrent checks on the frame engine top ports
module tbrfe_asserts #(
	parameter int FWT_BASE_ETU = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// rf front end
	input wire logic rf_mod_r,
	input wire logic carrier_on_r,
	// receive and status
	input wire logic rx_valid_r,
	input wire logic rx_done_r,
	input wire logic rx_crc_err_r,
	input wire logic rx_frame_err_r,
	input wire logic resp_timeout_r,
	input wire logic busy_r
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ETU = tbrfe_pkg::ETU_I;
	localparam int QUIET = ((FWT_BASE_ETU < 32) ? FWT_BASE_ETU : 32) * ETU - 8;
	logic prev_r;
	logic [19:0] len_r;
	// cycles spent at the current rf level
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			prev_r <= 1'b0;
			len_r <= 20'h00000;
		end
		else
		begin
			prev_r <= rf_mod_r;
			len_r <= (rf_mod_r != prev_r) ? 20'h00001 : len_r + 20'h00001;
		end
	end
	a_carrier_stays_on: assert property (@(posedge clock) disable iff (reset)
		$past(carrier_on_r) |-> carrier_on_r)
		else $error("carrier switched off");
	a_mod_run_etu: assert property (@(posedge clock) disable iff (reset)
		$fell(rf_mod_r) |-> (len_r % 20'(ETU) == 20'h0) && (len_r <= 20'(10 * ETU)))
		else $error("modulated run not whole etu");
	a_crc_err_done: assert property (@(posedge clock) disable iff (reset)
		rx_crc_err_r |-> rx_done_r && !rx_frame_err_r)
		else $error("crc error outside frame end");
	a_frame_err_done: assert property (@(posedge clock) disable iff (reset)
		rx_frame_err_r |-> rx_done_r)
		else $error("frame error outside frame end");
	a_quiet_timeout: assert property (@(posedge clock) disable iff (reset)
		resp_timeout_r |-> !rf_mod_r && len_r >= 20'(QUIET))
		else $error("timeout too early or field modulated");
	a_done_quiet: assert property (@(posedge clock) disable iff (reset)
		rx_done_r |-> !rf_mod_r && len_r > 20'(8 * ETU))
		else $error("field modulated during response");
	a_valid_pulse: assert property (@(posedge clock) disable iff (reset)
		rx_valid_r |=> !rx_valid_r [*8])
		else $error("received bytes too close");
	a_busy_in_frame: assert property (@(posedge clock) disable iff (reset)
		rf_mod_r && $past(rf_mod_r) |-> busy_r)
		else $error("modulation while idle");
endmodule : tbrfe_asserts

bind tbrfe_top tbrfe_asserts #(.FWT_BASE_ETU(FWT_BASE_ETU)) u_asserts (.clock(clock),
	.reset(reset), .rf_mod_r(rf_mod_r), .carrier_on_r(carrier_on_r), .rx_valid_r(rx_valid_r),
	.rx_done_r(rx_done_r), .rx_crc_err_r(rx_crc_err_r), .rx_frame_err_r(rx_frame_err_r),
	.resp_timeout_r(resp_timeout_r), .busy_r(busy_r));

// ==== test_type_b_rf_frame_engine.sv ====
// self-checking bench for the type b frame engine
module test_type_b_rf_frame_engine;
	timeunit 1ns;
	timeprecision 1ns;
	typedef logic [7:0] tbrfe_bytes_t [$];
	localparam int ETU = tbrfe_pkg::ETU_I;
	localparam int BASE = 12;
	logic clock;
	logic reset;
	logic tx_valid;
	logic tx_ready;
	logic [7:0] tx_data;
	logic tx_last;
	logic [3:0] fwi;
	logic atqb_wait;
	logic rf_mod_r;
	logic carrier_on_r;
	logic sub_on_pin;
	logic sub_phase_pin;
	logic [7:0] rx_data_r;
	logic rx_valid_r;
	logic rx_done_r;
	logic rx_crc_err_r;
	logic rx_frame_err_r;
	logic resp_timeout_r;
	logic tx_underrun_r;
	logic busy_r;
	logic c_go;
	logic [7:0] c_resp [0:2];
	logic [9:0] c_gap;
	int errors;
	int total_checks;
	int refused;
	tbrfe_top #(.FWT_BASE_ETU(BASE)) DUT (.clock(clock), .reset(reset), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .fwi(fwi),
		.atqb_wait(atqb_wait), .rf_mod_r(rf_mod_r), .carrier_on_r(carrier_on_r),
		.sub_on_pin(sub_on_pin), .sub_phase_pin(sub_phase_pin), .rx_data_r(rx_data_r),
		.rx_valid_r(rx_valid_r), .rx_done_r(rx_done_r), .rx_crc_err_r(rx_crc_err_r),
		.rx_frame_err_r(rx_frame_err_r), .resp_timeout_r(resp_timeout_r),
		.tx_underrun_r(tx_underrun_r), .busy_r(busy_r));
	tbrfe_card card (.clock(clock), .rf_mod(rf_mod_r), .go(c_go), .resp(c_resp), .gap(c_gap),
		.sub_on_pin(sub_on_pin), .sub_phase_pin(sub_phase_pin));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	task automatic guard(input int k, input int lim);
		if (k >= lim)
		begin
			errors++;
			end_of_test();
		end
	endtask : guard
	// crc register shifted msb first, fed in line order, crc bit 15 sent first
	function automatic tbrfe_bytes_t with_crc(input tbrfe_bytes_t b);
		logic [15:0] c;
		logic [7:0] r1;
		logic [7:0] r2;
		c = 16'hffff;
		foreach (b[i])
			for (int j = 0; j < 8; j++)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][j]) ? 16'h1021 : 16'h0000);
		r1 = {<<{c[15:8]}};
		r2 = {<<{c[7:0]}};
		return {b, r1, r2};
	endfunction : with_crc
	task automatic expect_etu(input logic v, input int n);
		repeat (n)
		begin
			check(16'(rf_mod_r), 16'(v));
			repeat (ETU) @(negedge clock);
		end
	endtask : expect_etu
	task automatic push(input tbrfe_bytes_t b);
		int k;
		foreach (b[i])
		begin
			tx_data = b[i];
			tx_last = (i == b.size() - 1);
			tx_valid = 1'b1;
			for (k = 0; tx_ready !== 1'b1 && k < 30000; k++)
			begin
				refused++;
				@(negedge clock);
			end
			guard(k, 30000);
			@(negedge clock);
		end
		tx_valid = 1'b0;
	endtask : push
	task automatic tx_line(input tbrfe_bytes_t b);
		int k;
		for (k = 0; rf_mod_r !== 1'b1 && k < 100; k++)
			@(negedge clock);
		guard(k, 100);
		repeat (ETU / 2) @(negedge clock);
		expect_etu(1'b1, 10);
		expect_etu(1'b0, 2);
		foreach (b[i])
		begin
			expect_etu(1'b1, 1);
			for (k = 0; k < 8; k++)
				expect_etu(!b[i][k], 1);
			expect_etu(1'b0, 1);
		end
		expect_etu(1'b1, 10);
	endtask : tx_line
	task automatic wait_timeout(input int lim);
		int k;
		logic quiet;
		quiet = 1'b1;
		for (k = ETU / 2; resp_timeout_r !== 1'b1 && k < 70 * ETU; k++)
		begin
			quiet &= (rf_mod_r === 1'b0);
			@(negedge clock);
		end
		guard(k, 70 * ETU);
		check(16'(quiet), 16'h0001);
		check(16'(k > lim * ETU - 20 && k < lim * ETU + 20), 16'h0001);
		check(16'(busy_r), 16'h0001);
		repeat (2) @(negedge clock);
		check(16'(busy_r), 16'h0000);
	endtask : wait_timeout
	// nine bytes overfill the fifo; limit from fwi shifted once
	task automatic s_long_frame();
		tbrfe_bytes_t b;
		b = '{8'h00, 8'hff, 8'ha5, 8'h01, 8'h80, 8'h5a, 8'h3c, 8'hc3, 8'h7e};
		atqb_wait = 1'b0;
		fwi = 4'h1;
		refused = 0;
		fork
			push(b);
			tx_line(with_crc(b));
		join
		check(16'(refused > 0), 16'h0001);
		wait_timeout(2 * BASE);
	endtask : s_long_frame
	// lone byte without its last mark: crc follows at once, underrun pulses
	task automatic s_poll_timeout();
		int k;
		int u;
		atqb_wait = 1'b1;
		fwi = 4'hf;
		u = 0;
		check(16'(tx_ready), 16'h0001);
		tx_data = 8'h05;
		tx_last = 1'b0;
		tx_valid = 1'b1;
		@(negedge clock);
		tx_valid = 1'b0;
		fork
			tx_line(with_crc('{8'h05}));
			for (k = 0; k < 40 * ETU; k++)
			begin
				u += int'(tx_underrun_r === 1'b1);
				@(negedge clock);
			end
		join
		check(16'(u), 16'h0001);
		wait_timeout(32);
	endtask : s_poll_timeout
	task automatic s_response(input logic [9:0] gap, input logic bad, input logic ferr);
		tbrfe_bytes_t r;
		tbrfe_bytes_t got;
		int k;
		logic ce;
		logic fe;
		r = with_crc('{8'h96});
		r[2] ^= {7'h00, bad};
		c_resp = '{r[0], r[1], r[2]};
		c_gap = gap;
		atqb_wait = 1'b0;
		fwi = 4'h1;
		c_go = 1'b1;
		push('{8'h50});
		for (k = 0; rx_done_r !== 1'b1 && k < 40000; k++)
		begin
			if (rx_valid_r === 1'b1)
				got.push_back(rx_data_r);
			@(negedge clock);
		end
		guard(k, 40000);
		ce = rx_crc_err_r;
		fe = rx_frame_err_r;
		c_go = 1'b0;
		check(16'(fe), 16'(ferr));
		if (!ferr)
		begin
			check(16'(ce), 16'(bad));
			check(16'(got.size()), 16'h0003);
			foreach (got[i])
				check(16'(got[i]), 16'(r[i]));
		end
		repeat (10) @(negedge clock);
	endtask : s_response
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial
	begin
		errors = 0;
		total_checks = 0;
		refused = 0;
		reset = 1'b1;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		tx_last = 1'b0;
		fwi = 4'h0;
		atqb_wait = 1'b0;
		c_go = 1'b0;
		c_gap = 10'h000;
		c_resp = '{8'h00, 8'h00, 8'h00};
		repeat (20) @(negedge clock);
		reset = 1'b0;
		repeat (2) @(negedge clock);
		check(16'(carrier_on_r), 16'h0001);
		s_long_frame();
		s_poll_timeout();
		s_response(10'h000, 1'b0, 1'b0);
		s_response(10'h17c, 1'b1, 1'b0);
		s_response(10'h258, 1'b0, 1'b1);
		end_of_test();
	end
endmodule : test_type_b_rf_frame_engine
